// *** core/seq_pkg.sv ***
// constants, codes and types for the channel sequencer and fast fault response
package seq_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS   = 40;
   localparam int TICK_NS         = 10000;
   localparam int OSC_TICK_CYC    = TICK_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_NS       = 12200;
   localparam int SAMPLE_CYC      = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHARE_LOSS_NS   = 40000;
   localparam int SHARE_LOSS_CYC  = SHARE_LOSS_NS / CLK_PERIOD_NS;

   // timer units are 10 us ticks
   localparam logic [6:0]  UNITS_PER_MS = 7'h64;
   localparam logic [20:0] UNITS_655MS  = 21'h00ffdc;
   localparam logic [20:0] UNITS_13S1   = 21'h13fd30;
   localparam int          L11_FRAC     = 16;

   // command codes
   localparam logic [7:0] CMD_OPERATION    = 8'h01;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OV_RESPONSE  = 8'h41;
   localparam logic [7:0] CMD_UV_RESPONSE  = 8'h45;
   localparam logic [7:0] CMD_OT_FAULT     = 8'h4f;
   localparam logic [7:0] CMD_OT_WARN      = 8'h51;
   localparam logic [7:0] CMD_UT_WARN      = 8'h52;
   localparam logic [7:0] CMD_UT_FAULT     = 8'h53;
   localparam logic [7:0] CMD_TON_DELAY    = 8'h60;
   localparam logic [7:0] CMD_TON_RISE     = 8'h61;
   localparam logic [7:0] CMD_TON_MAX      = 8'h62;
   localparam logic [7:0] CMD_TOFF_DELAY   = 8'h64;
   localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
   localparam logic [7:0] CMD_STATUS_VOUT  = 8'h7a;
   localparam logic [7:0] CMD_CHAN_CONFIG  = 8'hd0;
   localparam logic [7:0] CMD_RETRY_COUNT  = 8'hd1;

   // field positions
   localparam int OP_ON_BIT     = 7;
   localparam int CFG_FAST_OFF  = 0;
   localparam int CFG_DAC_LO    = 1;
   localparam int CFG_CURRENT   = 3;
   localparam int SV_OV_BIT     = 7;
   localparam int SV_UV_BIT     = 4;
   localparam int SV_TONMAX_BIT = 2;
   localparam int SB_VOUT_OV    = 5;
   localparam int SB_OTHER      = 0;
   localparam int SW_VOUT       = 15;

   // values after reset
   localparam logic [7:0]  RST_OPERATION = 8'h00;
   localparam logic [7:0]  RST_RESPONSE  = 8'h00;
   localparam logic [15:0] RST_L11       = 16'h0000;
   localparam logic [7:0]  RST_CONFIG    = 8'h00;
   localparam logic [2:0]  RST_RETRIES   = 3'h0;

   localparam logic [1:0] ACT_CONTINUE = 2'h0;
   localparam logic [1:0] DAC_SOFT     = 2'h0;

   typedef struct packed {
      logic [1:0] action;
      logic [2:0] retry;
      logic [2:0] delay;
   } fault_resp_t;

   typedef struct packed {
      logic wr;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_t;

   typedef enum logic [2:0] {
      ST_OFF       = 3'b000,
      ST_ON_DELAY  = 3'b001,
      ST_RISE      = 3'b010,
      ST_ON        = 3'b011,
      ST_OFF_DELAY = 3'b100,
      ST_FAULT_OFF = 3'b101
   } chan_state_t;

endpackage

// *** core/l11_ticks.sv ***
// L11 millisecond value to clamped, rounded count of 10 us ticks
`timescale 1ns/10ps
module l11_ticks
   import seq_pkg::*;
#(
   parameter logic [20:0] MAX_UNITS = UNITS_655MS,
   parameter bit          COARSE    = 1'b0
)(
   // raw value as written
   input  wire logic [15:0] l11_i,
   // effective duration
   output logic      [20:0] units_o
);

   logic signed [4:0] expo;
   logic [47:0]       scaled;
   logic [47:0]       rounded;
   logic [20:0]       fine;
   logic [21:0]       coarse;

   always_comb
   begin
      expo    = l11_i[15:11];
      scaled  = (48'(l11_i[9:0]) * 48'(UNITS_PER_MS)) << L11_FRAC;
      if (expo >= 0)
         scaled = scaled << expo;
      else
         scaled = scaled >> (-expo);
      rounded = (scaled + (48'h1 << (L11_FRAC - 1))) >> L11_FRAC;
      // negative mantissa means no delay; clamp the rest
      if (l11_i[10])
         fine = 21'h0;
      else if (rounded > 48'(MAX_UNITS))
         fine = MAX_UNITS;
      else
         fine = rounded[20:0];
      coarse = ((22'(fine) + 22'h00000a) / 22'h000014) * 22'h000014;
      if (COARSE && fine > UNITS_655MS)
         units_o = coarse[20:0];
      else
         units_o = fine;
   end

endmodule // l11_ticks

// *** core/chan_sequencer.sv ***
// one power channel: sequencing timers, fast supervisor faults, command registers
`timescale 1ns/10ps
module chan_sequencer
   import seq_pkg::*;
#(
   parameter bit ODD_CHANNEL = 1'b0
)(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rstn_i,
   // pins
   input  wire logic        share_clk_i,
   input  wire logic        channel_on_pin_i,
   input  wire logic        bias_ok_i,
   input  wire logic        ov_detect_i,
   input  wire logic        uv_detect_i,
   // command port
   input  wire cmd_t        cmd_i,
   input  wire logic [7:0]  rd_code_i,
   output logic      [15:0] rd_data_o,
   // channel outputs
   output logic             vout_enable_o,
   output logic             dac_connect_o,
   output logic             alert_out_n_o
);

   // pin synchronisers: share, on, bias, ov, uv
   localparam int NPIN = 5;
   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;
   logic [NPIN-1:0] pin_s3;
   logic [NPIN-1:0] pin_q;
   logic [NPIN-1:0] pin_rise;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end
      else
      begin
         pin_s1 <= {share_clk_i, channel_on_pin_i, bias_ok_i, ov_detect_i, uv_detect_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   always_comb
   begin
      pin_rise = pin_s2 & pin_s3 & ~pin_q;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pin_q <= '0;
      else
      begin
         for (int i = 0; i < NPIN; i++)
         begin
            if (pin_s2[i] == pin_s3[i])
               pin_q[i] <= pin_s3[i];
         end
      end
   end

   logic share_tick;
   logic pin_on;
   logic bias_ok;
   logic ov_det;
   logic uv_det;
   assign share_tick = pin_rise[4];
   assign pin_on     = pin_q[3];
   assign bias_ok    = pin_q[2];
   assign ov_det     = pin_q[1];
   assign uv_det     = pin_q[0];

   // time base: shared clock edges, oscillator fallback, supervisor samples
   logic [9:0] loss_cnt;
   logic       share_present;
   logic [8:0] osc_cnt;
   logic       osc_tick;
   logic [8:0] smp_cnt;
   logic       sample_tick;
   logic       any_tick;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         loss_cnt      <= '0;
         share_present <= 1'b0;
      end
      else if (share_tick)
      begin
         loss_cnt      <= '0;
         share_present <= 1'b1;
      end
      else if (loss_cnt == 10'(SHARE_LOSS_CYC - 1))
         share_present <= 1'b0;
      else
         loss_cnt <= loss_cnt + 10'h001;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         osc_cnt  <= '0;
         osc_tick <= 1'b0;
         smp_cnt  <= '0;
         sample_tick <= 1'b0;
      end
      else
      begin
         osc_tick    <= (osc_cnt == 9'(OSC_TICK_CYC - 1));
         osc_cnt     <= (osc_cnt == 9'(OSC_TICK_CYC - 1)) ? 9'h000 : osc_cnt + 9'h001;
         sample_tick <= (smp_cnt == 9'(SAMPLE_CYC - 1));
         smp_cnt     <= (smp_cnt == 9'(SAMPLE_CYC - 1)) ? 9'h000 : smp_cnt + 9'h001;
      end
   end

   assign any_tick = share_present ? share_tick : osc_tick;

   // command registers
   logic [15:0] ot_fault_lim;
   logic [15:0] ot_warn_lim;
   logic [15:0] ut_warn_lim;
   logic [15:0] ut_fault_lim;
   logic [15:0] ton_delay_raw;
   logic [15:0] ton_rise_raw;
   logic [15:0] ton_max_raw;
   logic [15:0] toff_delay_raw;
   logic [7:0]  operation;
   logic [7:0]  chan_config;
   logic [2:0]  retry_count;
   fault_resp_t resp [2];
   logic        clear_faults;

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         ot_fault_lim   <= RST_L11;
         ot_warn_lim    <= RST_L11;
         ut_warn_lim    <= RST_L11;
         ut_fault_lim   <= RST_L11;
         ton_delay_raw  <= RST_L11;
         ton_rise_raw   <= RST_L11;
         ton_max_raw    <= RST_L11;
         toff_delay_raw <= RST_L11;
         operation      <= RST_OPERATION;
         chan_config    <= RST_CONFIG;
         retry_count    <= RST_RETRIES;
         resp[0]        <= RST_RESPONSE;
         resp[1]        <= RST_RESPONSE;
      end
      else if (cmd_i.wr)
      begin
         unique case (cmd_i.code)
            CMD_OT_FAULT:    ot_fault_lim   <= cmd_i.data;
            CMD_OT_WARN:     ot_warn_lim    <= cmd_i.data;
            CMD_UT_WARN:     ut_warn_lim    <= cmd_i.data;
            CMD_UT_FAULT:    ut_fault_lim   <= cmd_i.data;
            CMD_TON_DELAY:   ton_delay_raw  <= cmd_i.data;
            CMD_TON_RISE:    ton_rise_raw   <= cmd_i.data;
            CMD_TON_MAX:     ton_max_raw    <= cmd_i.data;
            CMD_TOFF_DELAY:  toff_delay_raw <= cmd_i.data;
            CMD_OPERATION:   operation      <= cmd_i.data[7:0];
            CMD_CHAN_CONFIG: chan_config    <= cmd_i.data[7:0];
            CMD_RETRY_COUNT: retry_count    <= cmd_i.data[2:0];
            CMD_OV_RESPONSE: resp[0]        <= cmd_i.data[7:0];
            CMD_UV_RESPONSE: resp[1]        <= cmd_i.data[7:0];
            default:         ;
         endcase
      end
   end

   assign clear_faults = cmd_i.wr && cmd_i.code == CMD_CLEAR_FAULTS;

   // effective durations in 10 us ticks
   logic [20:0] ton_delay_u;
   logic [20:0] ton_rise_u;
   logic [20:0] ton_max_u;
   logic [20:0] toff_delay_u;

   l11_ticks #(.MAX_UNITS(UNITS_13S1), .COARSE(1'b1)) u_ton_delay (
      .l11_i   (ton_delay_raw),
      .units_o (ton_delay_u)
   );
   l11_ticks #(.MAX_UNITS(UNITS_13S1), .COARSE(1'b1)) u_toff_delay (
      .l11_i   (toff_delay_raw),
      .units_o (toff_delay_u)
   );
   l11_ticks #(.MAX_UNITS(UNITS_655MS), .COARSE(1'b0)) u_ton_rise (
      .l11_i   (ton_rise_raw),
      .units_o (ton_rise_u)
   );
   l11_ticks #(.MAX_UNITS(UNITS_655MS), .COARSE(1'b0)) u_ton_max (
      .l11_i   (ton_max_raw),
      .units_o (ton_max_u)
   );

   // fast supervisor deglitch, index 0 = OV, 1 = UV
   chan_state_t state;
   logic        uv_armed;
   logic        ignore_vout;
   logic [1:0]  fault_act;
   logic [1:0]  confirmed;
   logic [2:0]  dgl_cnt [2];
   logic        running;

   assign running     = state == ST_RISE || state == ST_ON;
   assign ignore_vout = ODD_CHANNEL && chan_config[CFG_CURRENT];

   always_comb
   begin
      fault_act[0] = running && ov_det && !ignore_vout;
      fault_act[1] = running && uv_det && uv_armed && !ignore_vout;
      for (int k = 0; k < 2; k++)
         confirmed[k] = fault_act[k] && dgl_cnt[k] >= resp[k].delay;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         dgl_cnt[0] <= '0;
         dgl_cnt[1] <= '0;
      end
      else
      begin
         for (int k = 0; k < 2; k++)
         begin
            if (!fault_act[k])
               dgl_cnt[k] <= '0;
            else if (sample_tick && dgl_cnt[k] != 3'h7)
               dgl_cnt[k] <= dgl_cnt[k] + 3'h1;
         end
      end
   end

   // status flags, set wins over clear
   logic stat_ov;
   logic stat_uv;
   logic stat_tonmax;
   logic next_stat_ov;
   logic next_stat_uv;
   logic next_stat_tonmax;
   logic tonmax_fault;

   always_comb
   begin
      next_stat_ov     = confirmed[0] | (stat_ov & ~clear_faults);
      next_stat_uv     = confirmed[1] | (stat_uv & ~clear_faults);
      next_stat_tonmax = tonmax_fault | (stat_tonmax & ~clear_faults);
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         stat_ov       <= 1'b0;
         stat_uv       <= 1'b0;
         stat_tonmax   <= 1'b0;
         alert_out_n_o <= 1'b1;
      end
      else
      begin
         stat_ov       <= next_stat_ov;
         stat_uv       <= next_stat_uv;
         stat_tonmax   <= next_stat_tonmax;
         alert_out_n_o <= ~(next_stat_ov | next_stat_uv | next_stat_tonmax);
      end
   end

   // channel sequencer
   logic        on_request;
   logic        shut_req;
   logic        fault_kind;
   logic        last_kind;
   logic        pend_fault;
   logic [2:0]  retries_left;
   logic [20:0] tmr;
   logic        rise_done;

   assign on_request = operation[OP_ON_BIT] && pin_on && bias_ok;
   assign rise_done  = tmr >= ton_rise_u;
   assign tonmax_fault = state == ST_RISE && !uv_armed && ton_max_u != 21'h0
                         && tmr >= ton_max_u;

   always_comb
   begin
      shut_req   = 1'b0;
      fault_kind = 1'b0;
      for (int k = 0; k < 2; k++)
      begin
         if (confirmed[k] && resp[k].action != ACT_CONTINUE)
         begin
            shut_req   = 1'b1;
            fault_kind = 1'(k);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state         <= ST_OFF;
         tmr           <= '0;
         uv_armed      <= 1'b0;
         pend_fault    <= 1'b0;
         last_kind     <= 1'b0;
         retries_left  <= '0;
         vout_enable_o <= 1'b0;
         dac_connect_o <= 1'b0;
      end
      else if (!bias_ok && state != ST_OFF)
      begin
         state         <= ST_OFF;
         vout_enable_o <= 1'b0;
         dac_connect_o <= 1'b0;
         uv_armed      <= 1'b0;
         retries_left  <= '0;
         pend_fault    <= 1'b0;
      end
      else if (shut_req && state != ST_OFF_DELAY)
      begin
         dac_connect_o <= 1'b0;
         uv_armed      <= 1'b0;
         tmr           <= '0;
         pend_fault    <= 1'b1;
         last_kind     <= fault_kind;
         if (fault_kind != last_kind)
            retries_left <= '0;
         if (chan_config[CFG_FAST_OFF])
         begin
            state         <= ST_FAULT_OFF;
            vout_enable_o <= 1'b0;
         end
         else
            state <= ST_OFF_DELAY;
      end
      else
      begin
         unique case (state)
            ST_OFF:
            begin
               if (on_request)
               begin
                  state        <= ST_ON_DELAY;
                  tmr          <= '0;
                  retries_left <= retry_count;
               end
            end
            ST_ON_DELAY:
            begin
               if (!on_request)
                  state <= ST_OFF;
               else if (tmr >= ton_delay_u)
               begin
                  state         <= ST_RISE;
                  tmr           <= '0;
                  vout_enable_o <= 1'b1;
               end
               else if (share_tick)
                  tmr <= tmr + 21'h1;
            end
            ST_RISE:
            begin
               if (!uv_det)
                  uv_armed <= 1'b1;
               if (rise_done && chan_config[CFG_DAC_LO +: 2] == DAC_SOFT)
                  dac_connect_o <= 1'b1;
               if (!on_request)
               begin
                  state <= ST_OFF_DELAY;
                  tmr   <= '0;
               end
               else if (tonmax_fault)
               begin
                  state         <= ST_FAULT_OFF;
                  vout_enable_o <= 1'b0;
                  dac_connect_o <= 1'b0;
                  pend_fault    <= 1'b1;
                  retries_left  <= '0;
               end
               else if (uv_armed && rise_done)
                  state <= ST_ON;
               else if (any_tick && tmr != UNITS_655MS)
                  tmr <= tmr + 21'h1;
            end
            ST_ON:
            begin
               if (!on_request)
               begin
                  state <= ST_OFF_DELAY;
                  tmr   <= '0;
               end
            end
            ST_OFF_DELAY:
            begin
               if (tmr >= toff_delay_u)
               begin
                  state         <= pend_fault ? ST_FAULT_OFF : ST_OFF;
                  vout_enable_o <= 1'b0;
                  dac_connect_o <= 1'b0;
                  uv_armed      <= 1'b0;
               end
               else if (any_tick)
                  tmr <= tmr + 21'h1;
            end
            ST_FAULT_OFF:
            begin
               if (!on_request || clear_faults)
               begin
                  state      <= ST_OFF;
                  pend_fault <= 1'b0;
               end
               else if (resp[last_kind].retry != 3'h0 && retries_left != 3'h0)
               begin
                  state        <= ST_ON_DELAY;
                  tmr          <= '0;
                  pend_fault   <= 1'b0;
                  retries_left <= retries_left - 3'h1;
               end
            end
            default:
               state <= ST_OFF;
         endcase
      end
   end

   // read back, L11 values exactly as written, narrower registers zero-extended
   logic [7:0] status_byte;
   logic [7:0] status_vout;

   always_comb
   begin
      status_vout                = '0;
      status_vout[SV_OV_BIT]     = stat_ov;
      status_vout[SV_UV_BIT]     = stat_uv;
      status_vout[SV_TONMAX_BIT] = stat_tonmax;
      status_byte                = '0;
      status_byte[SB_VOUT_OV]    = stat_ov;
      status_byte[SB_OTHER]      = stat_uv | stat_tonmax;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rd_data_o <= '0;
      else
      begin
         unique case (rd_code_i)
            CMD_OT_FAULT:    rd_data_o <= ot_fault_lim;
            CMD_OT_WARN:     rd_data_o <= ot_warn_lim;
            CMD_UT_WARN:     rd_data_o <= ut_warn_lim;
            CMD_UT_FAULT:    rd_data_o <= ut_fault_lim;
            CMD_TON_DELAY:   rd_data_o <= ton_delay_raw;
            CMD_TON_RISE:    rd_data_o <= ton_rise_raw;
            CMD_TON_MAX:     rd_data_o <= ton_max_raw;
            CMD_TOFF_DELAY:  rd_data_o <= toff_delay_raw;
            CMD_OPERATION:   rd_data_o <= {8'h00, operation};
            CMD_CHAN_CONFIG: rd_data_o <= {8'h00, chan_config};
            CMD_RETRY_COUNT: rd_data_o <= {13'h0000, retry_count};
            CMD_OV_RESPONSE: rd_data_o <= {8'h00, resp[0]};
            CMD_UV_RESPONSE: rd_data_o <= {8'h00, resp[1]};
            CMD_STATUS_BYTE: rd_data_o <= {8'h00, status_byte};
            CMD_STATUS_WORD: rd_data_o <= {|status_vout, 7'h00, status_byte};
            CMD_STATUS_VOUT: rd_data_o <= {8'h00, status_vout};
            default:         rd_data_o <= '0;
         endcase
      end
   end

endmodule // chan_sequencer

// *** verification/chan_seq_sva.sv ***
// concurrent checks on the channel sequencer ports
`timescale 1ns/10ps
module chan_seq_sva
   import seq_pkg::*;
(
   // clock and reset
   input wire logic        clock_i,
   input wire logic        rstn_i,
   // pins and commands
   input wire logic        share_clk_i,
   input wire logic        channel_on_pin_i,
   input wire logic        bias_ok_i,
   input wire logic        ov_detect_i,
   input wire logic        uv_detect_i,
   input wire cmd_t        cmd_i,
   input wire logic [7:0]  rd_code_i,
   // outputs
   input wire logic [15:0] rd_data_o,
   input wire logic        vout_enable_o,
   input wire logic        dac_connect_o,
   input wire logic        alert_out_n_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rstn_i);

   dac_needs_en_a: assert property (dac_connect_o |-> vout_enable_o)
      else $error("dac connected while enable low");
   dac_rise_a: assert property ($rose(dac_connect_o) |-> $past(vout_enable_o))
      else $error("dac connected in enable cycle");
   bias_off_a: assert property (!bias_ok_i [*8] |-> !vout_enable_o)
      else $error("enable held after bias loss");
   clear_alert_a: assert property ((!ov_detect_i && !uv_detect_i) [*6] ##0
      (cmd_i.wr && cmd_i.code == CMD_CLEAR_FAULTS) |=> alert_out_n_o)
      else $error("alert kept after clear");
   delay_read_a: assert property (cmd_i.wr && cmd_i.code == CMD_TON_DELAY ##1
      (rd_code_i == CMD_TON_DELAY && !(cmd_i.wr && cmd_i.code == CMD_TON_DELAY))
      |=> rd_data_o == $past(cmd_i.data, 2))
      else $error("timer read differs from write");
   limit_read_a: assert property (cmd_i.wr && cmd_i.code == CMD_OT_FAULT ##1
      (rd_code_i == CMD_OT_FAULT && !(cmd_i.wr && cmd_i.code == CMD_OT_FAULT))
      |=> rd_data_o == $past(cmd_i.data, 2))
      else $error("limit read differs from write");
   status_alert_a: assert property (rd_code_i == CMD_STATUS_WORD |=>
      ((rd_data_o == 16'h0000) == $past(alert_out_n_o)))
      else $error("alert disagrees with status");
   status_wr_a: assert property (cmd_i.wr && cmd_i.code == CMD_STATUS_VOUT
      && alert_out_n_o ##1 rd_code_i == CMD_STATUS_VOUT && alert_out_n_o
      |=> rd_data_o == 16'h0000)
      else $error("status took a write");
endmodule // chan_seq_sva

// *** verification/dcdc_model.sv ***
// converter output and shared sync clock source
`timescale 1ns/10ps
module dcdc_model (
   // controls
   input  wire logic clock_i,
   input  wire logic en_i,
   input  wire logic stuck_i,
   input  wire logic ov_req_i,
   input  wire logic share_on_i,
   // comparators and shared clock
   output logic      uv_o,
   output logic      ov_o,
   output logic      share_o
);
   int   up_cnt = 0;
   int   sh_cnt = 0;
   logic low_q  = 1'b1;
   logic sh_q   = 1'b0;
   // slow ramp up after enable, slow decay after disable
   always_ff @(posedge clock_i)
   begin
      if (en_i && up_cnt < 50)
         up_cnt <= up_cnt + 1;
      else if (!en_i && up_cnt > 0)
         up_cnt <= up_cnt - 1;
      if (en_i && up_cnt == 50)
         low_q <= 1'b0;
      else if (!en_i && up_cnt == 0)
         low_q <= 1'b1;
   end
   // shared clock, period 20 cycles, still while off
   always_ff @(posedge clock_i)
   begin
      if (share_on_i)
         sh_cnt <= (sh_cnt == 9) ? 0 : sh_cnt + 1;
      if (share_on_i && sh_cnt == 9)
         sh_q <= ~sh_q;
   end
   assign uv_o    = low_q | stuck_i;
   assign ov_o    = ov_req_i;
   assign share_o = sh_q;
endmodule // dcdc_model

// *** verification/tb.sv ***
// self-checking bench for one sequencer channel
`timescale 1ns/10ps
module tb;
   import seq_pkg::*;
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        on_pin = 1'b0;
   logic        bias = 1'b1;
   logic        ov_req = 1'b0;
   logic        stuck = 1'b0;
   logic        share_on = 1'b1;
   cmd_t        cmd = '0;
   logic [7:0]  rd_code = 8'h00;
   logic [15:0] rd_data;
   logic        en, dac, alert_n, uv, ov, share;
   wire [2:0]   outs = {alert_n, dac, en};
   int          miscompares = 0;
   int          n_checks = 0;

   chan_sequencer #(.ODD_CHANNEL(1'b1)) i_chan_sequencer (.clock_i(clock_i), .rstn_i(rstn_i),
      .share_clk_i(share), .channel_on_pin_i(on_pin), .bias_ok_i(bias), .ov_detect_i(ov),
      .uv_detect_i(uv),
      .cmd_i(cmd), .rd_code_i(rd_code), .rd_data_o(rd_data), .vout_enable_o(en),
      .dac_connect_o(dac), .alert_out_n_o(alert_n));
   dcdc_model i_dcdc_model (.clock_i(clock_i), .en_i(en), .stuck_i(stuck), .ov_req_i(ov_req),
      .share_on_i(share_on), .uv_o(uv), .ov_o(ov), .share_o(share));

   initial
   begin
      forever #20 clock_i = ~clock_i;
   end

   task automatic test_done();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      @(negedge clock_i);
      cmd = '{1'b1, c, d};
      rd_code = c;
      @(negedge clock_i);
      cmd.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      @(negedge clock_i);
      rd_code = c;
      repeat (2) @(negedge clock_i);
      `CHK("rd_data", e, rd_data)
   endtask

   // output k must stay off v for lo cycles, then reach v within hi
   task automatic wt(input string nm, input int k, input logic v, input int lo, input int hi);
      int i;
      i = 0;
      while (outs[k] !== v && i < lo + hi)
      begin
         @(negedge clock_i);
         i++;
      end
      `CHK(nm, 1'b1, i >= lo)
      if (hi > 0 && outs[k] !== v)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, v, outs[k]);
         test_done();
      end
   endtask

   task automatic s_regs();
      logic [7:0] codes [10] = '{CMD_OT_FAULT, CMD_OT_WARN, CMD_UT_WARN, CMD_UT_FAULT,
         CMD_TON_DELAY, CMD_TON_RISE, CMD_TON_MAX, CMD_TOFF_DELAY, CMD_OV_RESPONSE,
         CMD_UV_RESPONSE};
      logic [15:0] d;
      for (int i = 0; i < 10; i++)
      begin
         d = 16'hd3ff ^ 16'(i);
         wr(codes[i], d);
         rd(codes[i], (i < 8) ? d : {8'h00, d[7:0]});
      end
      rd(8'hee, 16'h0000);
      wr(CMD_STATUS_VOUT, 16'hffff);
      rd(CMD_STATUS_VOUT, 16'h0000);
   endtask

   task automatic s_on();
      wr(CMD_CHAN_CONFIG, 16'h0001);
      wr(CMD_TON_DELAY, 16'hf001);
      wr(CMD_TON_RISE, 16'hf001);
      wr(CMD_TON_MAX, 16'h0000);
      wr(CMD_TOFF_DELAY, 16'hf001);
      wr(CMD_OV_RESPONSE, 16'h0000);
      wr(CMD_UV_RESPONSE, 16'h0000);
      share_on = 1'b0;
      wr(CMD_OPERATION, 16'h0080);
      on_pin = 1'b1;
      wt("on_hold", 0, 1'b1, 8000, 0);
      share_on = 1'b1;
      wt("on_delay", 0, 1'b1, 440, 200);
      wt("dac_rise", 1, 1'b1, 440, 200);
   endtask

   task automatic s_faults();
      wr(CMD_CHAN_CONFIG, 16'h0009);
      ov_req = 1'b1;
      wt("odd_ign", 2, 1'b0, 300, 0);
      wr(CMD_CHAN_CONFIG, 16'h0001);
      wt("ov_alert", 2, 1'b0, 0, 20);
      wt("ov_keep", 0, 1'b0, 600, 0);
      ov_req = 1'b0;
      rd(CMD_STATUS_WORD, 16'h8020);
      rd(CMD_STATUS_VOUT, 16'h0080);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt("alert_clr", 2, 1'b1, 0, 3);
      rd(CMD_STATUS_VOUT, 16'h0000);
      wr(CMD_OV_RESPONSE, 16'h0043);
      ov_req = 1'b1;
      wt("deglitch", 0, 1'b0, 600, 700);
      ov_req = 1'b0;
      wt("latched", 0, 1'b1, 2000, 0);
      rd(CMD_STATUS_VOUT, 16'h0080);
      wr(CMD_RETRY_COUNT, 16'h0001);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt("restart", 0, 1'b1, 440, 200);
      wr(CMD_CHAN_CONFIG, 16'h0000);
      wr(CMD_OV_RESPONSE, 16'h0088);
      ov_req = 1'b1;
      wt("seq_off", 0, 1'b0, 440, 200);
      ov_req = 1'b0;
      wt("retry", 0, 1'b1, 440, 200);
      rd(CMD_STATUS_VOUT, 16'h0080);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt("dac_up", 1, 1'b1, 0, 800);
      on_pin = 1'b0;
      wt("toff", 0, 1'b0, 440, 200);
   endtask

   task automatic s_ton_max();
      stuck = 1'b1;
      on_pin = 1'b1;
      wt("on3", 0, 1'b1, 440, 200);
      wt("no_max", 2, 1'b0, 3000, 0);
      on_pin = 1'b0;
      wt("off3", 0, 1'b0, 440, 200);
      wr(CMD_TON_MAX, 16'hf001);
      on_pin = 1'b1;
      wt("on4", 0, 1'b1, 440, 200);
      wt("max_flt", 2, 1'b0, 440, 200);
      rd(CMD_STATUS_VOUT, 16'h0004);
      stuck = 1'b0;
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      wt("on5", 0, 1'b1, 0, 800);
      bias = 1'b0;
      wt("bias_off", 0, 1'b0, 0, 10);
      repeat (10) @(negedge clock_i);
   endtask

   initial
   begin
      repeat (3) @(negedge clock_i);
      rstn_i = 1'b1;
      s_regs();
      s_on();
      s_faults();
      s_ton_max();
      test_done();
   end
endmodule // tb

bind chan_sequencer chan_seq_sva i_chan_seq_sva (.clock_i(clock_i), .rstn_i(rstn_i),
   .share_clk_i(share_clk_i), .channel_on_pin_i(channel_on_pin_i), .bias_ok_i(bias_ok_i),
   .ov_detect_i(ov_detect_i), .uv_detect_i(uv_detect_i), .cmd_i(cmd_i),
   .rd_code_i(rd_code_i), .rd_data_o(rd_data_o), .vout_enable_o(vout_enable_o),
   .dac_connect_o(dac_connect_o), .alert_out_n_o(alert_out_n_o));
